/* epi_consts.svh */
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH

// register indices, byte address is four times the index
`define EPI_IDX_PC_MASK      8'h10
`define EPI_IDX_PC_FLAG      8'h11
`define EPI_IDX_PC_CONTROL   8'h12
`define EPI_IDX_EXT_MASK     8'h13
`define EPI_IDX_EXT_FLAG     8'h14
`define EPI_IDX_EXT_SENSE    8'h15

// field positions
`define EPI_BIT_ENABLE       0
`define EPI_BIT_FLAG         0
`define EPI_SENSE_LSB        0
`define EPI_SENSE_MSB        1

// reset values
`define EPI_RST_PC_MASK      4'h0
`define EPI_RST_SENSE        2'h0
`define EPI_RST_BIT          1'b0

// sense encodings
`define EPI_SENSE_LOW        2'h0
`define EPI_SENSE_CHANGE     2'h1
`define EPI_SENSE_FALL       2'h2
`define EPI_SENSE_RISE       2'h3

// program word addresses of entries
`define EPI_VEC_RESET        10'h000
`define EPI_VEC_EXT          10'h001
`define EPI_VEC_PIN_CHANGE   10'h002
`define EPI_VEC_TIMER_CAPT   10'h003
`define EPI_VEC_TIMER_OVF    10'h004
`define EPI_VEC_TIMER_CMPA   10'h005
`define EPI_VEC_TIMER_CMPB   10'h006
`define EPI_VEC_COMPARATOR   10'h007
`define EPI_VEC_WATCHDOG     10'h008
`define EPI_VEC_SUPPLY_MON   10'h009
`define EPI_VEC_CONVERTER    10'h00A

`endif

/* epi_pkg.sv */
package epi_pkg;

	typedef enum logic {
		bus_idle,
		bus_data
	} epi_bus_state_type;

endpackage

/* epi_pin_change.sv */
`timescale 1ns/1ps

module epi_pin_change #(
	parameter int N = 4
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         clk_en,
	// pins and selection
	input  wire logic [N-1:0] pins,
	input  wire logic [N-1:0] mask,
	// result
	output logic      [N-1:0] mismatch
);

	logic [N-1:0] reference;

	// per-pin reference level, compared without a clock edge
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					reference[i] <= 1'b0;
				end else if (clk_en) begin
					reference[i] <= pins[i];
				end
			end
			assign mismatch[i] = mask[i] & (pins[i] ^ reference[i]);
		end
	endgenerate

endmodule

/* epi_ext_irq.sv */
`timescale 1ns/1ps
`include "epi_consts.svh"

module epi_ext_irq #(
	parameter int PC_N  = 4,
	parameter int VEC_W = 10
) (
	// clock, reset, i/o clock enable
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              clk_en,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// pins
	input  wire logic              ext_irq_pin,
	input  wire logic [PC_N-1:0]   pin_change_inputs,
	// core interrupt sequencer
	input  wire logic              status_global_enable,
	input  wire logic              irq_ack,
	output logic                   irq_request,
	output logic      [VEC_W-1:0]  irq_vector,
	output logic                   wake_request
);

	epi_pkg::epi_bus_state_type bus_state;
	logic              rd_q;
	logic [7:0]        idx_q;
	logic              hit_q;
	logic              accept;
	logic              commit;
	logic              wr_ext_flag;
	logic              wr_pc_flag;
	logic [PC_N-1:0]   pin_change_mask;
	logic              pin_change_group_enable;
	logic              pin_change_group_flag;
	logic              ext_irq_enable;
	logic              ext_pin_flag;
	logic [1:0]        sense_select;
	logic              pin_sample;
	logic              pin_prev;
	logic              edge_hit;
	logic              level_low;
	logic [PC_N-1:0]   pc_mismatch;
	logic              pc_event;
	logic              ext_pend;
	logic              pc_pend;
	logic              ack_ext;
	logic              ack_pc;
	logic [31:0]       next_rdata;
	logic              next_request;
	logic [VEC_W-1:0]  next_vector;

	// bus decode
	assign accept = hsel & htrans[1] & hready;
	assign commit = (bus_state == epi_pkg::bus_data) & clk_en;
	assign wr_ext_flag = commit & !rd_q & hit_q & (idx_q == `EPI_IDX_EXT_FLAG)
		& hwdata[`EPI_BIT_FLAG];
	assign wr_pc_flag = commit & !rd_q & hit_q & (idx_q == `EPI_IDX_PC_FLAG)
		& hwdata[`EPI_BIT_FLAG];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state <= epi_pkg::bus_idle;
			rd_q      <= 1'b0;
			idx_q     <= 8'h00;
			hit_q     <= 1'b0;
			hreadyout <= 1'b1;
		end else if (clk_en) begin
			unique case (bus_state)
				epi_pkg::bus_idle: begin
					if (accept) begin
						bus_state <= epi_pkg::bus_data;
						rd_q      <= !hwrite;
						idx_q     <= haddr[9:2];
						hit_q     <= (haddr[31:10] == 22'h00_0000) & (haddr[1:0] == 2'h0);
						hreadyout <= 1'b0;
					end
				end
				epi_pkg::bus_data: begin
					bus_state <= epi_pkg::bus_idle;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// read mux, unmapped reads zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_q) begin
			unique case (idx_q)
				`EPI_IDX_PC_MASK:    next_rdata[PC_N-1:0] = pin_change_mask;
				`EPI_IDX_PC_FLAG:    next_rdata[`EPI_BIT_FLAG] = pin_change_group_flag;
				`EPI_IDX_PC_CONTROL: next_rdata[`EPI_BIT_ENABLE] = pin_change_group_enable;
				`EPI_IDX_EXT_MASK:   next_rdata[`EPI_BIT_ENABLE] = ext_irq_enable;
				`EPI_IDX_EXT_FLAG:   next_rdata[`EPI_BIT_FLAG] =
					ext_pin_flag & (sense_select != `EPI_SENSE_LOW);
				`EPI_IDX_EXT_SENSE:  next_rdata[`EPI_SENSE_MSB:`EPI_SENSE_LSB] = sense_select;
				default:             next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (commit && rd_q) begin
			hrdata <= next_rdata;
		end
	end

	// control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_change_mask         <= PC_N'(`EPI_RST_PC_MASK);
			pin_change_group_enable <= `EPI_RST_BIT;
			ext_irq_enable          <= `EPI_RST_BIT;
			sense_select            <= `EPI_RST_SENSE;
		end else if (commit && !rd_q && hit_q) begin
			unique case (idx_q)
				`EPI_IDX_PC_MASK:    pin_change_mask <= hwdata[PC_N-1:0];
				`EPI_IDX_PC_CONTROL: pin_change_group_enable <= hwdata[`EPI_BIT_ENABLE];
				`EPI_IDX_EXT_MASK:   ext_irq_enable <= hwdata[`EPI_BIT_ENABLE];
				`EPI_IDX_EXT_SENSE:  sense_select <= hwdata[`EPI_SENSE_MSB:`EPI_SENSE_LSB];
				default:             sense_select <= sense_select;
			endcase
		end
	end

	// pin sampling; pin levels are seen whatever the pin direction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_sample <= 1'b1;
			pin_prev   <= 1'b1;
		end else if (clk_en) begin
			pin_sample <= ext_irq_pin;
			pin_prev   <= pin_sample;
		end
	end

	// sense selection on the sampled pin
	always_comb begin
		unique case (sense_select)
			`EPI_SENSE_CHANGE: edge_hit = pin_sample ^ pin_prev;
			`EPI_SENSE_FALL:   edge_hit = pin_prev & !pin_sample;
			`EPI_SENSE_RISE:   edge_hit = !pin_prev & pin_sample;
			default:           edge_hit = 1'b0;
		endcase
	end
	assign level_low = (sense_select == `EPI_SENSE_LOW) & !pin_sample;

	epi_pin_change #(
		.N        (PC_N)
	) u_pin_change (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.clk_en   (clk_en),
		.pins     (pin_change_inputs),
		.mask     (pin_change_mask),
		.mismatch (pc_mismatch)
	);
	assign pc_event = |pc_mismatch;

	// service entry clears the flag of the vector being presented
	assign ack_ext = irq_ack & irq_request & (irq_vector == `EPI_VEC_EXT);
	assign ack_pc  = irq_ack & irq_request & (irq_vector == `EPI_VEC_PIN_CHANGE);

	// external flag, set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_pin_flag <= `EPI_RST_BIT;
		end else if (clk_en) begin
			if (sense_select == `EPI_SENSE_LOW) begin
				ext_pin_flag <= 1'b0;
			end else if (edge_hit) begin
				ext_pin_flag <= 1'b1;
			end else if (ack_ext || wr_ext_flag) begin
				ext_pin_flag <= 1'b0;
			end
		end
	end

	// pin-change flag, set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_change_group_flag <= `EPI_RST_BIT;
		end else if (clk_en) begin
			if (pc_event) begin
				pin_change_group_flag <= 1'b1;
			end else if (ack_pc || wr_pc_flag) begin
				pin_change_group_flag <= 1'b0;
			end
		end
	end

	// request gating and priority
	assign ext_pend = status_global_enable & ext_irq_enable
		& (level_low | ext_pin_flag);
	assign pc_pend = status_global_enable & pin_change_group_enable
		& pin_change_group_flag;

	always_comb begin
		next_request = ext_pend | pc_pend;
		next_vector  = `EPI_VEC_RESET;
		if (ext_pend) begin
			next_vector = `EPI_VEC_EXT;
		end else if (pc_pend) begin
			next_vector = `EPI_VEC_PIN_CHANGE;
		end
	end

	// a level removed before service simply drops the request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_request <= 1'b0;
			irq_vector  <= `EPI_VEC_RESET;
		end else if (clk_en) begin
			irq_request <= next_request;
			irq_vector  <= next_vector;
		end
	end

	// wake path runs while the i/o clock is halted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= (ext_irq_enable & (sense_select == `EPI_SENSE_LOW)
				& !ext_irq_pin)
				| (pin_change_group_enable & pc_event);
		end
	end

	// checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_flag_low_mode;
		clk_en && sense_select == `EPI_SENSE_LOW |=> !ext_pin_flag;
	endproperty
	a_flag_low_mode: assert property (p_flag_low_mode)
		else $error("flag set in low-level mode");

	property p_rise_sets_flag;
		clk_en && sense_select == `EPI_SENSE_RISE && !pin_prev && pin_sample
			|=> ext_pin_flag;
	endproperty
	a_rise_sets_flag: assert property (p_rise_sets_flag)
		else $error("rising edge missed");

	property p_pulse_caught;
		clk_en && sense_select == `EPI_SENSE_FALL && $rose(clk_en) == 1'b0
			&& pin_sample && !ext_irq_pin ##1 clk_en ##1 clk_en |=> ext_pin_flag;
	endproperty
	a_pulse_caught: assert property (p_pulse_caught)
		else $error("falling pulse missed");

	property p_pc_sets_flag;
		clk_en && pc_event |=> pin_change_group_flag;
	endproperty
	a_pc_sets_flag: assert property (p_pc_sets_flag)
		else $error("pin change missed");

	property p_priority;
		clk_en && ext_pend && pc_pend |=> irq_request && irq_vector == `EPI_VEC_EXT;
	endproperty
	a_priority: assert property (p_priority)
		else $error("wrong vector priority");

	property p_global_gate;
		clk_en && !status_global_enable |=> !irq_request;
	endproperty
	a_global_gate: assert property (p_global_gate)
		else $error("request without global enable");

	property p_level_request;
		clk_en && sense_select == `EPI_SENSE_LOW && !pin_sample && ext_irq_enable
			&& status_global_enable |=> irq_request && irq_vector == `EPI_VEC_EXT;
	endproperty
	a_level_request: assert property (p_level_request)
		else $error("low level not requesting");

	property p_w1c;
		wr_pc_flag && !pc_event |=> !pin_change_group_flag;
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write one did not clear");

	property p_idle_vector;
		clk_en && !ext_pend && !pc_pend |=> !irq_request && irq_vector == `EPI_VEC_RESET;
	endproperty
	a_idle_vector: assert property (p_idle_vector)
		else $error("vector not at reset entry");

	property p_wake;
		pin_change_group_enable && pc_event |=> wake_request;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake on pin change");

	property p_bus_answer;
		clk_en && accept && bus_state == epi_pkg::bus_idle ##1 clk_en
			|-> !hreadyout ##1 hreadyout && !hresp;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer late");

	c_ext_edge: cover property (ack_ext);
	c_pc_entry: cover property (ack_pc);
	c_both_pending: cover property (ext_pend && pc_pend);
	c_wake_halted: cover property (!clk_en && wake_request);

endmodule

/* epi_core_model.sv */
`timescale 1ns/1ps

module epi_core_model (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// behaviour select
	input  wire logic       ack_on,
	input  wire logic [3:0] ack_delay,
	// interrupt port
	input  wire logic       irq_request,
	input  wire logic [9:0] irq_vector,
	output logic            irq_ack,
	output logic      [9:0] last_vector,
	output logic      [7:0] ack_count
);
	logic [3:0] wait_cnt;
	logic [1:0] guard;

	// enters service after ack_delay cycles, then two guard cycles before the next ack
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ack     <= 1'b0;
			last_vector <= 10'h000;
			ack_count   <= 8'h00;
			wait_cnt    <= 4'h0;
			guard       <= 2'h0;
		end else begin
			irq_ack <= 1'b0;
			if (guard != 2'h0) begin
				guard <= guard - 2'h1;
			end else if (ack_on && irq_request === 1'b1) begin
				if (wait_cnt == ack_delay) begin
					irq_ack     <= 1'b1;
					last_vector <= irq_vector;
					ack_count   <= ack_count + 8'h01;
					wait_cnt    <= 4'h0;
					guard       <= 2'h2;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end else begin
				wait_cnt <= 4'h0;
			end
		end
	end
endmodule

/* tb_external_pin_interrupt_unit.sv */
`timescale 1ns/1ps
`include "epi_consts.svh"

module tb_external_pin_interrupt_unit;
	logic        hclk;
	logic        hresetn;
	logic        clk_en;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        ext_irq_pin;
	logic [3:0]  pin_change_inputs;
	logic        status_global_enable;
	logic        irq_ack;
	logic        irq_request;
	logic [9:0]  irq_vector;
	logic        wake_request;
	logic        ack_on;
	logic [3:0]  ack_delay;
	logic [9:0]  last_vector;
	logic [7:0]  ack_count;
	logic [7:0]  c0;
	logic [31:0] rd;
	logic [31:0] rw_exp [7];
	int          errors;
	int          checks_done;
	int          n;
	int          i;

	epi_ext_irq dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ext_irq_pin(ext_irq_pin), .pin_change_inputs(pin_change_inputs),
		.status_global_enable(status_global_enable), .irq_ack(irq_ack),
		.irq_request(irq_request), .irq_vector(irq_vector), .wake_request(wake_request));

	epi_core_model core (.hclk(hclk), .hresetn(hresetn), .ack_on(ack_on),
		.ack_delay(ack_delay), .irq_request(irq_request), .irq_vector(irq_vector),
		.irq_ack(irq_ack), .last_vector(last_vector), .ack_count(ack_count));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic end_of_test();
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge hclk);
	endtask

	// single word transfer, address phase then data phase
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {22'h00_0000, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		for (n = 0; n < 20 && hreadyout !== 1'b1; n++) @(posedge hclk);
		chk({31'h0000_0000, hreadyout}, 32'h0000_0001);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		for (n = 0; n < 20 && hreadyout !== 1'b1; n++) @(posedge hclk);
		chk({31'h0000_0000, hreadyout}, 32'h0000_0001);
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		xfer(1'b1, idx, wd);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic wait_acks(input logic [7:0] k);
		for (n = 0; n < 80 && (ack_count - c0) < k; n++) @(posedge hclk);
		chk({24'h00_0000, ack_count - c0}, {24'h00_0000, k});
	endtask

	task automatic wait_wake(input logic lvl);
		for (n = 0; n < 10 && wake_request !== lvl; n++) @(posedge hclk);
	endtask

	initial begin
		#100000;
		errors++;
		end_of_test();
	end

	initial begin
		hresetn = 1'b0;
		clk_en = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		ext_irq_pin = 1'b1;
		pin_change_inputs = 4'h0;
		status_global_enable = 1'b0;
		ack_on = 1'b0;
		ack_delay = 4'h0;
		errors = 0;
		checks_done = 0;
		rw_exp = '{32'h0000_000F, 32'h0000_0000, 32'h0000_0001, 32'h0000_0001,
			32'h0000_0000, 32'h0000_0003, 32'h0000_0000};
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({22'h00_0000, irq_vector}, 32'h0000_0000);
		for (i = 0; i < 7; i++) rdchk(8'h10 + 8'(i), 32'h0000_0000);
		for (i = 0; i < 7; i++) begin
			wr(8'h10 + 8'(i), 32'hFFFF_FFFF);
			rdchk(8'h10 + 8'(i), rw_exp[i]);
			wr(8'h10 + 8'(i), 32'h0000_0000);
		end
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			wr(`EPI_IDX_EXT_SENSE, 32'(i));
			wr(`EPI_IDX_EXT_FLAG, 32'h0000_0001);
			ext_irq_pin <= 1'b0;
			tick(4);
			rdchk(`EPI_IDX_EXT_FLAG, {31'h0000_0000, i[1] ^ i[0]});
			wr(`EPI_IDX_EXT_FLAG, 32'h0000_0001);
			ext_irq_pin <= 1'b1;
			tick(4);
			rdchk(`EPI_IDX_EXT_FLAG, {31'h0000_0000, i[0]});
			wr(`EPI_IDX_EXT_FLAG, 32'h0000_0001);
		end
		$display("test sense modes done");
		wr(`EPI_IDX_EXT_SENSE, 32'h0000_0003);
		ext_irq_pin <= 1'b0;
		wr(`EPI_IDX_EXT_MASK, 32'h0000_0001);
		ext_irq_pin <= 1'b1;
		tick(4);
		chk({31'h0000_0000, irq_request}, 32'h0000_0000);
		c0 = ack_count;
		ack_delay <= 4'h3;
		ack_on <= 1'b1;
		status_global_enable <= 1'b1;
		wait_acks(8'h01);
		chk({22'h00_0000, last_vector}, 32'h0000_0001);
		ack_on <= 1'b0;
		tick(3);
		rdchk(`EPI_IDX_EXT_FLAG, 32'h0000_0000);
		$display("test delivery done");
		wr(`EPI_IDX_EXT_SENSE, 32'h0000_0000);
		c0 = ack_count;
		ack_delay <= 4'h0;
		ack_on <= 1'b1;
		ext_irq_pin <= 1'b0;
		tick(20);
		chk({31'h0000_0000, (ack_count - c0) >= 8'h02}, 32'h0000_0001);
		rdchk(`EPI_IDX_EXT_FLAG, 32'h0000_0000);
		ext_irq_pin <= 1'b1;
		tick(4);
		chk({31'h0000_0000, irq_request}, 32'h0000_0000);
		ack_on <= 1'b0;
		$display("test level done");
		wr(`EPI_IDX_EXT_MASK, 32'h0000_0000);
		wr(`EPI_IDX_PC_MASK, 32'h0000_0004);
		wr(`EPI_IDX_PC_FLAG, 32'h0000_0001);
		pin_change_inputs <= 4'h1;
		tick(4);
		rdchk(`EPI_IDX_PC_FLAG, 32'h0000_0000);
		pin_change_inputs <= 4'h5;
		tick(4);
		rdchk(`EPI_IDX_PC_FLAG, 32'h0000_0001);
		wr(`EPI_IDX_PC_FLAG, 32'h0000_0001);
		rdchk(`EPI_IDX_PC_FLAG, 32'h0000_0000);
		pin_change_inputs <= 4'h1;
		c0 = ack_count;
		ack_on <= 1'b1;
		wr(`EPI_IDX_PC_CONTROL, 32'h0000_0001);
		wait_acks(8'h01);
		chk({22'h00_0000, last_vector}, 32'h0000_0002);
		ack_on <= 1'b0;
		tick(3);
		rdchk(`EPI_IDX_PC_FLAG, 32'h0000_0000);
		$display("test pin change done");
		wr(`EPI_IDX_EXT_SENSE, 32'h0000_0003);
		wr(`EPI_IDX_EXT_MASK, 32'h0000_0001);
		ext_irq_pin <= 1'b0;
		wr(`EPI_IDX_EXT_FLAG, 32'h0000_0001);
		ext_irq_pin <= 1'b1;
		pin_change_inputs <= 4'h5;
		tick(4);
		chk({22'h00_0000, irq_vector}, 32'h0000_0001);
		c0 = ack_count;
		ack_on <= 1'b1;
		wait_acks(8'h02);
		chk({22'h00_0000, last_vector}, 32'h0000_0002);
		ack_on <= 1'b0;
		$display("test priority done");
		status_global_enable <= 1'b0;
		wr(`EPI_IDX_EXT_SENSE, 32'h0000_0000);
		clk_en <= 1'b0;
		ext_irq_pin <= 1'b0;
		wait_wake(1'b1);
		chk({31'h0000_0000, wake_request}, 32'h0000_0001);
		ext_irq_pin <= 1'b1;
		wait_wake(1'b0);
		chk({31'h0000_0000, wake_request}, 32'h0000_0000);
		pin_change_inputs <= 4'h1;
		wait_wake(1'b1);
		chk({31'h0000_0000, wake_request}, 32'h0000_0001);
		clk_en <= 1'b1;
		tick(2);
		$display("test wake done");
		end_of_test();
	end
endmodule
